// ---- bench/init_and_park_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module init_and_park_sequencer_bench;
   logic core_clk = 1'h0, resetn = 1'h0, fast_park_request_low = 1'h1, slow = 1'h0;
   logic projection_enable = 1'h1, pll_locked, flash_load_done, flash_oe, light_select_a;
   logic mirror_enable_reset_low, host_init_flag, flash_load_start, park_active, parked;
   logic [19:0] pat = 20'hA5C3F, gpio_oe, gpio_out;
   logic flash_serial_clock, flash_serial_data_out, flash_select_a_low, flash_select_b_low;
   logic light_select_b;
   logic [4:0] flash_view;
   logic [23:0] quiet_view;
   assign flash_view = {flash_oe, flash_select_b_low, flash_select_a_low, flash_serial_data_out,
      flash_serial_clock};
   assign quiet_view = {flash_oe, gpio_oe, light_select_a, light_select_b,
      mirror_enable_reset_low};
   int mismatches = 0, checked = 0;
   always #2 core_clk = ~core_clk;
   ips_far_model far (.core_clk, .resetn, .slow, .pll_locked, .flash_load_done);
   ips_sequencer #(.FAST_PARK_CYC(20), .NORMAL_PARK_CYC(50)) uut (.core_clk, .resetn,
      .fast_park_request_low, .projection_enable, .pll_locked, .flash_load_done, .flash_oe,
      .flash_serial_clock_core(pat[0]), .flash_serial_data_out_core(pat[1]), .gpio_oe,
      .flash_select_a_low_core(pat[2]), .flash_select_b_low_core(pat[3]), .gpio_out_core(pat),
      .gpio_oe_core(pat), .light_select_core(pat[1:0]), .flash_serial_clock, .gpio_out,
      .flash_serial_data_out, .flash_select_a_low, .flash_select_b_low, .light_select_a,
      .light_select_b, .mirror_enable_reset_low, .host_init_flag, .flash_load_start,
      .park_active, .parked);
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %0t %0h %0h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic start(input logic s, input int n);
      resetn = 1'h0;
      slow = s;
      projection_enable = 1'h1;
      fast_park_request_low = 1'h1;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      chk(quiet_view, 24'h0);
      resetn = 1'h1;
      repeat (2) @(negedge core_clk);
      chk(host_init_flag, 24'h1);
      chk({19'h0, flash_view}, {19'h0, 1'h1, pat[3:0]});
      chk({4'h0, gpio_out}, {4'h0, pat});
      chk({4'h0, gpio_oe}, {4'h0, pat});
      repeat (n) if (host_init_flag !== 1'h0) @(negedge core_clk);
   endtask
   task automatic t_fast;
      start(1'h0, 300);
      @(negedge core_clk);
      chk({host_init_flag, mirror_enable_reset_low, light_select_a}, 24'h3);
      chk(light_select_b, {23'h0, pat[1]});
      fast_park_request_low = 1'h0;
      repeat (40) @(negedge core_clk);
      chk({parked, park_active, mirror_enable_reset_low, light_select_b}, 24'h8);
   endtask
   task automatic t_normal;
      pat = ~pat;
      start(1'h1, 300);
      @(negedge core_clk);
      chk({host_init_flag, mirror_enable_reset_low, light_select_a}, 24'h2);
      chk(light_select_b, {23'h0, pat[1]});
      projection_enable = 1'h0;
      repeat (40) @(negedge core_clk);
      chk({parked, park_active}, 24'h1);
      repeat (30) @(negedge core_clk);
      chk({parked, park_active}, 24'h2);
   endtask
   task automatic t_abort;
      start(1'h1, 9);
      fast_park_request_low = 1'h0;
      repeat (40) @(negedge core_clk);
      chk({host_init_flag, parked}, 24'h1);
   endtask
   task automatic t_park_abort;
      start(1'h0, 300);
      projection_enable = 1'h0;
      repeat (10) @(negedge core_clk);
      chk(park_active, 24'h1);
      fast_park_request_low = 1'h0;
      repeat (30) @(negedge core_clk);
      chk({parked, park_active, mirror_enable_reset_low}, 24'h4);
   endtask
   initial begin
      t_fast;
      t_normal;
      t_abort;
      t_park_abort;
      give_verdict;
   end
   initial begin
      #4000;
      mismatches++;
      give_verdict;
   end
endmodule
`default_nettype wire

// ---- bench/ips_checker_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ips_checker (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic fast_park_request_low,
   input wire logic pll_locked,
   input wire logic light_select_a,
   input wire logic mirror_enable_reset_low,
   input wire logic host_init_flag,
   input wire logic flash_load_start,
   input wire logic park_active,
   input wire logic parked
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_lock; flash_load_start |-> $past(pll_locked, 2) && host_init_flag; endproperty
   a_lock: assert property (p_lock) else $error("early load");
   property p_pulse; flash_load_start |=> !flash_load_start; endproperty
   a_pulse: assert property (p_pulse) else $error("long load");
   property p_done; $fell(host_init_flag) && fast_park_request_low |-> mirror_enable_reset_low;
   endproperty
   a_done: assert property (p_done) else $error("bad done");
   property p_fast; $fell(fast_park_request_low) && !parked |-> ##[1:5] park_active; endproperty
   a_fast: assert property (p_fast) else $error("no park");
   property p_abort; $fell(fast_park_request_low) |-> ##[1:6] !host_init_flag; endproperty
   a_abort: assert property (p_abort) else $error("no abort");
   property p_bound; park_active |-> ##[1:80] !park_active; endproperty
   a_bound: assert property (p_bound) else $error("slow park");
   property p_dark; parked |-> !mirror_enable_reset_low ##1 parked; endproperty
   a_dark: assert property (p_dark) else $error("lit park");
   property p_light; light_select_a |-> mirror_enable_reset_low && !park_active; endproperty
   a_light: assert property (p_light) else $error("stray light");
endmodule
bind ips_sequencer ips_checker u_chk (.*);
`default_nettype wire

// ---- bench/ips_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ips_far_model (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic slow,
   output logic pll_locked,
   output logic flash_load_done
);
   logic [7:0] up_q;
   assign pll_locked = up_q > (slow ? 8'h28 : 8'h04);
   assign flash_load_done = up_q == (slow ? 8'h50 : 8'h0C);
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) up_q <= 8'h00;
      else if (up_q != 8'hFF) up_q <= up_q + 8'h01;
   end
endmodule
`default_nettype wire

// ---- logic/ips_consts.svh ----
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH

`define IPS_CLK_MHZ 250
`define IPS_FAST_PARK_US 32
`define IPS_NORMAL_PARK_MS 20
`define IPS_FAST_PARK_CYC ((`IPS_FAST_PARK_US * `IPS_CLK_MHZ) - 1)
`define IPS_NORMAL_PARK_CYC (((`IPS_NORMAL_PARK_MS * 1000 * `IPS_CLK_MHZ) * 9) / 10)
`define IPS_GPIO_W 20
`define IPS_LIGHT_RESET 2'h0
`define IPS_SYNC_RESET 3'h4

`endif

// ---- logic/ips_pkg.sv ----
package ips_pkg;
   typedef enum logic [2:0] {
      IPS_PLL_LOCK,
      IPS_FLASH_LOAD,
      IPS_RUN,
      IPS_NORMAL_PARK,
      IPS_FAST_PARK,
      IPS_PARKED
   } ips_state_type;
endpackage

// ---- logic/ips_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ips_consts.svh"
module ips_sequencer #(
   parameter int FAST_PARK_CYC = `IPS_FAST_PARK_CYC,
   parameter int NORMAL_PARK_CYC = `IPS_NORMAL_PARK_CYC,
   parameter int CNT_W = 24
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic fast_park_request_low,
   input wire logic projection_enable,
   input wire logic pll_locked,
   input wire logic flash_load_done,
   input wire logic flash_serial_clock_core,
   input wire logic flash_serial_data_out_core,
   input wire logic flash_select_a_low_core,
   input wire logic flash_select_b_low_core,
   input wire logic [`IPS_GPIO_W-1:0] gpio_out_core,
   input wire logic [`IPS_GPIO_W-1:0] gpio_oe_core,
   input wire logic [1:0] light_select_core,
   output logic flash_serial_clock,
   output logic flash_serial_data_out,
   output logic flash_select_a_low,
   output logic flash_select_b_low,
   output logic flash_oe,
   output logic [`IPS_GPIO_W-1:0] gpio_out,
   output logic [`IPS_GPIO_W-1:0] gpio_oe,
   output logic light_select_a,
   output logic light_select_b,
   output logic mirror_enable_reset_low,
   output logic host_init_flag,
   output logic flash_load_start,
   output logic park_active,
   output logic parked
);
   // Park timer loads, cut to the counter width
   localparam logic [CNT_W-1:0] FAST_CNT = CNT_W'(FAST_PARK_CYC);
   localparam logic [CNT_W-1:0] NORM_CNT = CNT_W'(NORMAL_PARK_CYC);

   logic [2:0] sync_q;
   logic park_low_s;
   logic proj_s;
   logic lock_s;
   logic proj_armed_q;
   ips_pkg::ips_state_type state_q;
   logic [CNT_W-1:0] cnt_q;
   logic fast_hit;
   logic norm_hit;
   logic park_run;
   logic cnt_zero;

   // Park request resets to its idle high, so release is no park edge
   ips_sync #(.WIDTH(3), .INIT(`IPS_SYNC_RESET)) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in({fast_park_request_low, projection_enable, pll_locked}),
      .sync_out(sync_q)
   );
   assign park_low_s = sync_q[2];
   assign proj_s = sync_q[1];
   assign lock_s = sync_q[0];

   // Fast park from any state but fast park and parked, so it also cuts a normal park short
   assign fast_hit = !park_low_s && state_q != ips_pkg::IPS_FAST_PARK
                     && state_q != ips_pkg::IPS_PARKED;
   // Projection fall counts only once it has been seen high
   assign norm_hit = proj_armed_q && !proj_s;
   assign park_run = state_q == ips_pkg::IPS_NORMAL_PARK
                     || state_q == ips_pkg::IPS_FAST_PARK;
   assign cnt_zero = cnt_q == '0;

   // Normal park only after projection was seen on once
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         proj_armed_q <= 1'b0;
      end else if (proj_s) begin
         proj_armed_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ips_pkg::IPS_PLL_LOCK;
      end else if (fast_hit) begin
         state_q <= ips_pkg::IPS_FAST_PARK;
      end else begin
         case (state_q)
            ips_pkg::IPS_PLL_LOCK: begin
               if (lock_s) begin
                  state_q <= ips_pkg::IPS_FLASH_LOAD;
               end
            end
            ips_pkg::IPS_FLASH_LOAD: begin
               if (flash_load_done) begin
                  state_q <= ips_pkg::IPS_RUN;
               end
            end
            ips_pkg::IPS_RUN: begin
               if (norm_hit) begin
                  state_q <= ips_pkg::IPS_NORMAL_PARK;
               end
            end
            ips_pkg::IPS_NORMAL_PARK: begin
               if (cnt_zero) begin
                  state_q <= ips_pkg::IPS_PARKED;
               end
            end
            ips_pkg::IPS_FAST_PARK: begin
               if (cnt_zero) begin
                  state_q <= ips_pkg::IPS_PARKED;
               end
            end
            // Parked is terminal until the next reset
            ips_pkg::IPS_PARKED: begin
               state_q <= ips_pkg::IPS_PARKED;
            end
            default: begin
               state_q <= ips_pkg::IPS_PLL_LOCK;
            end
         endcase
      end
   end

   // Park timer: loaded on entry to a park, counts down to zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
      end else if (fast_hit) begin
         cnt_q <= FAST_CNT;
      end else if (state_q == ips_pkg::IPS_RUN && norm_hit) begin
         cnt_q <= NORM_CNT;
      end else if (park_run && !cnt_zero) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         host_init_flag <= 1'b0;
      end else begin
         host_init_flag <= (state_q == ips_pkg::IPS_PLL_LOCK
                            || state_q == ips_pkg::IPS_FLASH_LOAD)
                           && park_low_s;
      end
   end

   // Loader starts one cycle after lock is seen
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flash_load_start <= 1'b0;
      end else begin
         flash_load_start <= state_q == ips_pkg::IPS_PLL_LOCK && lock_s && park_low_s;
      end
   end

   // Park status levels follow the state
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         park_active <= 1'b0;
         parked <= 1'b0;
      end else begin
         park_active <= park_run;
         parked <= state_q == ips_pkg::IPS_PARKED;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flash_serial_clock <= 1'b0;
         flash_serial_data_out <= 1'b0;
         flash_select_a_low <= 1'b0;
         flash_select_b_low <= 1'b0;
         flash_oe <= 1'b0;
      end else begin
         flash_serial_clock <= flash_serial_clock_core;
         flash_serial_data_out <= flash_serial_data_out_core;
         flash_select_a_low <= flash_select_a_low_core;
         flash_select_b_low <= flash_select_b_low_core;
         flash_oe <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gpio_out <= '0;
         gpio_oe <= '0;
      end else begin
         gpio_out <= gpio_out_core;
         gpio_oe <= gpio_oe_core;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         {light_select_b, light_select_a} <= `IPS_LIGHT_RESET;
      end else begin
         light_select_a <= light_select_core[0] && state_q == ips_pkg::IPS_RUN;
         light_select_b <= light_select_core[1] && state_q == ips_pkg::IPS_RUN;
      end
   end

   // Mirror enabled while loading and running, dark in both parks
   // mirror low in reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mirror_enable_reset_low <= 1'b0;
      end else begin
         mirror_enable_reset_low <= state_q == ips_pkg::IPS_FLASH_LOAD
                                    || state_q == ips_pkg::IPS_RUN;
      end
   end
endmodule
`default_nettype wire

// ---- logic/ips_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module ips_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= INIT;
         sync_out <= INIT;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire
